// File: rtl/psr_device.sv
// Device end: four-wire serial slave with a four-page register map.
//
// Operation
// - Four pages, 128 locations each.
// - Location zero of each page selects page.
// - Page 0 is active after reset.
// - Page write moves page unless auto return.
// - Host reads page register back after change.
// - Frame is command byte then data byte.
// - First seven bits form the address.
// - Address decoded after the seventh bit.
// - Eighth bit is direction, polarity selectable.
// - Host drives eight write data bits.
// - Device shifts out read data byte.
// - Address and data go MSB first.
// - Select polarity is configurable.
// - Inactive select resets the serial port.
// - Output driven only in read data half.
// - CPOL sets the clock idle level.
// - Sample edge follows CPOL equals CPHA.
// - Host uses matching CPOL and CPHA.
// - Link select chooses four or two wire.
// - Shutdown request resets link when enabled.
// - Host leaves configuration alone during transfers.
// - Device works at host clock up to 14 MHz.
//
// Implementation choices: the APB register port and the register offsets.
module psr_device
    import psr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    psr_link_if.device link,
    input wire logic select_polarity,
    input wire logic direction_polarity,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic page_auto_return,
    input wire logic host_link_select,
    input wire logic link_reset_enable,
    input wire logic shutdown_request_pin,
    output logic [1:0] active_page,
    output logic four_wire_active
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] sdi_sync_r;
    logic [1:0] sd_sync_r;
    logic sck_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_r <= 2'h0;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            sd_sync_r <= 2'h0;
            sck_prev_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], link.select_n_line};
            sck_sync_r <= {sck_sync_r[0], link.serial_clock_line};
            sdi_sync_r <= {sdi_sync_r[0], link.sdi};
            sd_sync_r <= {sd_sync_r[0], shutdown_request_pin};
            sck_prev_r <= sck_sync_r[1];
        end
    end

    // ****************************************
    // Mode and edge decode
    // ****************************************
    logic cs_active;
    logic rise;
    logic fall;
    logic sample_edge;
    logic update_edge;
    logic port_reset;

    // The link selection is registered every clock, so four_wire_active takes the inverse of host_link_select one cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            four_wire_active <= 1'b0;
        end else begin
            four_wire_active <= !host_link_select;
        end
    end

    assign cs_active = (cs_sync_r[1] == select_polarity) && four_wire_active;
    assign rise = sck_sync_r[1] && !sck_prev_r;
    assign fall = !sck_sync_r[1] && sck_prev_r;
    assign sample_edge = (cpol == cpha) ? rise : fall;
    assign update_edge = (cpol == cpha) ? fall : rise;
    assign port_reset = !cs_active || (link_reset_enable && !sd_sync_r[1]);

    // ****************************************
    // Frame shifter
    // ****************************************
    logic [BITCNT_W-1:0] bit_cnt_r;
    logic [6:0] addr_r;
    logic dir_read_r;
    logic [7:0] shift_in_r;
    logic [7:0] shift_out_r;
    logic [7:0] rd_value;
    logic addr_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_r <= '0;
            addr_r <= 7'h00;
            dir_read_r <= 1'b0;
            shift_in_r <= 8'h00;
        end else if (port_reset) begin
            bit_cnt_r <= '0;
            dir_read_r <= 1'b0;
        end else if (sample_edge && bit_cnt_r < BITCNT_W'(FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r < BITCNT_W'(ADDR_BITS)) begin
                addr_r <= {addr_r[5:0], sdi_sync_r[1]};
            end else if (bit_cnt_r == BITCNT_W'(ADDR_BITS)) begin
                dir_read_r <= (sdi_sync_r[1] == direction_polarity);
            end else begin
                shift_in_r <= {shift_in_r[6:0], sdi_sync_r[1]};
            end
        end
    end

    assign addr_bit = 1'b0;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] regs_r [PAGES][PAGE_REGS];
    logic [6:0] dec_addr;
    logic write_done;

    // The address is complete after the seventh sample, before direction.
    assign dec_addr = addr_r;
    assign write_done = !port_reset && sample_edge && !dir_read_r
        && bit_cnt_r == BITCNT_W'(FRAME_BITS - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_page <= PAGE_RESET;
        end else if (write_done && dec_addr == PAGE_CTRL_ADDR) begin
            // The last data bit is still on the synchroniser when the frame completes.
            active_page <= page_auto_return ? PAGE_RESET : {shift_in_r[0], sdi_sync_r[1]};
        end else if (write_done && page_auto_return) begin
            active_page <= PAGE_RESET;
        end else if (!port_reset && sample_edge && dir_read_r
                && bit_cnt_r == BITCNT_W'(FRAME_BITS - 1) && page_auto_return
                && dec_addr != PAGE_CTRL_ADDR) begin
            active_page <= PAGE_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < PAGES; p++) begin
                for (int a = 0; a < PAGE_REGS; a++) begin
                    regs_r[p][a] <= REG_RESET;
                end
            end
        end else if (write_done && dec_addr != PAGE_CTRL_ADDR) begin
            regs_r[active_page][dec_addr] <= {shift_in_r[6:0], sdi_sync_r[1]};
        end
    end

    // Location zero reads back the active page rather than stored contents.
    assign rd_value = (dec_addr == PAGE_CTRL_ADDR) ? {6'h00, active_page}
        : regs_r[active_page][dec_addr];

    // ****************************************
    // Read output
    // ****************************************
    logic drive_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_out_r <= 8'h00;
            drive_r <= 1'b0;
        end else if (port_reset) begin
            drive_r <= 1'b0;
        end else if (sample_edge && bit_cnt_r == BITCNT_W'(ADDR_BITS)
                && (sdi_sync_r[1] == direction_polarity)) begin
            shift_out_r <= rd_value;
            drive_r <= 1'b1;
        end else if (update_edge && drive_r && bit_cnt_r > BITCNT_W'(CMD_END_BIT)) begin
            shift_out_r <= {shift_out_r[6:0], addr_bit};
        end
    end

    assign link.sdo_o = shift_out_r[7];
    assign link.sdo_oe_n = !drive_r;

endmodule

// File: rtl/psr_pkg.sv
// Package of shared constants and types for the paged serial register link.
package psr_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_END_BIT = 7;
    localparam int CMD_END_BIT = 8;
    localparam int BITCNT_W = 5;

    // ****************************************
    // Register map
    // ****************************************
    localparam int PAGES = 4;
    localparam int PAGE_REGS = 128;
    localparam logic [6:0] PAGE_CTRL_ADDR = 7'h00;
    localparam logic [1:0] PAGE_RESET = 2'h0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************
    // Host controller registers (APB byte offsets)
    // ****************************************
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0c;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int PCLK_HZ = 40_000_000;
    localparam int SCLK_MAX_HZ = 14_000_000;
    localparam int HALF_PERIOD_CYCLES_MIN = (PCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int HALF_PERIOD_DEFAULT = 4;
    localparam int GAP_CYCLES = 4;

    typedef enum logic [1:0] {
        PSR_IDLE = 2'b00,
        PSR_SHIFT = 2'b01,
        PSR_GAP = 2'b10
    } psr_host_state_e;

endpackage

// File: rtl/psr_link_if.sv
// Interface joining the serial host end and the register device end.
interface psr_link_if;
    logic select_n_line;
    logic serial_clock_line;
    logic sdi;
    logic sdo_o;
    logic sdo_oe_n;
    logic sdo;

    assign sdo = sdo_oe_n ? 1'b1 : sdo_o;

    modport host (
        output select_n_line,
        output serial_clock_line,
        output sdi,
        input sdo
    );

    modport device (
        input select_n_line,
        input serial_clock_line,
        input sdi,
        output sdo_o,
        output sdo_oe_n
    );
endinterface

// File: rtl/psr_host.sv
// Host end: APB-controlled four-wire serial master for the paged register port.
module psr_host
    import psr_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_PERIOD_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    psr_link_if.host link
);

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] cfg_r;
    logic [15:0] frame_r;
    logic [7:0] rdata_r;
    logic start;
    logic busy;
    logic done_r;
    logic sel_pol;
    logic dir_pol;
    logic cpol;
    logic cpha;
    logic apb_wr;

    assign sel_pol = cfg_r[0];
    assign dir_pol = cfg_r[1];
    assign cpol = cfg_r[2];
    assign cpha = cfg_r[3];
    assign apb_wr = psel && penable && pwrite;
    assign start = apb_wr && paddr == OFS_CMD && !busy;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == OFS_CFG || paddr == OFS_CMD
        || paddr == OFS_STATUS || paddr == OFS_RDATA);

    // Configuration may change only while idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RESET;
        end else if (apb_wr && paddr == OFS_CFG && !busy) begin
            cfg_r <= {28'h0000000, pwdata[3:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CFG: prdata <= cfg_r;
                OFS_STATUS: prdata <= {30'h0, done_r, busy};
                OFS_RDATA: prdata <= {24'h000000, rdata_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Serial engine
    // ****************************************
    psr_host_state_e state_r;
    logic [7:0] div_r;
    logic [5:0] edge_cnt_r;
    logic sck_r;
    logic is_read_r;
    logic tick;

    assign busy = state_r != PSR_IDLE;
    assign tick = div_r == 8'(HALF_PERIOD - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PSR_IDLE;
            div_r <= 8'h00;
            edge_cnt_r <= '0;
            sck_r <= 1'b0;
            frame_r <= 16'h0000;
            is_read_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            div_r <= (tick || state_r == PSR_IDLE) ? 8'h00 : div_r + 8'h01;
            unique case (state_r)
                PSR_IDLE: begin
                    sck_r <= cpol;
                    if (start) begin
                        // Command is addr[14:8], read flag bit 15, data [7:0].
                        is_read_r <= pwdata[15];
                        frame_r <= {pwdata[14:8], pwdata[15] ~^ dir_pol,
                            pwdata[7:0]};
                        edge_cnt_r <= '0;
                        done_r <= 1'b0;
                        state_r <= PSR_SHIFT;
                    end
                end
                PSR_SHIFT: begin
                    if (tick) begin
                        edge_cnt_r <= edge_cnt_r + 6'h01;
                        // Thirty-two edges, then half a period of hold before select drops.
                        if (edge_cnt_r < 6'(2 * FRAME_BITS)) begin
                            sck_r <= !sck_r;
                        end
                        // Phase 1 shows the first bit before its leading edge, so none is lost.
                        if (edge_cnt_r[0] != cpha && !(cpha && edge_cnt_r == 6'h00)) begin
                            frame_r <= {frame_r[14:0], 1'b0};
                        end else if (is_read_r && edge_cnt_r >= 6'(2 * DATA_BITS)
                                && edge_cnt_r < 6'(2 * FRAME_BITS)) begin
                            rdata_r <= {rdata_r[6:0], link.sdo};
                        end
                        if (edge_cnt_r == 6'(2 * FRAME_BITS)) begin
                            state_r <= PSR_GAP;
                            edge_cnt_r <= 6'h00;
                        end
                    end
                end
                PSR_GAP: begin
                    sck_r <= cpol;
                    if (tick) begin
                        edge_cnt_r <= edge_cnt_r + 6'h01;
                        if (edge_cnt_r == 6'(GAP_CYCLES)) begin
                            done_r <= 1'b1;
                            state_r <= PSR_IDLE;
                        end
                    end
                end
                default: state_r <= PSR_IDLE;
            endcase
        end
    end

    // A read sets the data line idle high in the data half.
    assign link.select_n_line = (state_r == PSR_SHIFT) ? sel_pol : !sel_pol;
    assign link.serial_clock_line = sck_r;
    // The idle level starts on an update edge so the direction bit is never disturbed.
    assign link.sdi = (is_read_r && edge_cnt_r >= 6'(2 * DATA_BITS) + 6'(cpha)) ? 1'b1
        : frame_r[15];

endmodule

// File: verification/psr_link_sva.sv
// Concurrent checks on the serial link between the host end and the device end.
module psr_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic select_n_line,
    input wire logic serial_clock_line,
    input wire logic sdi,
    input wire logic sdo_oe_n,
    input wire logic select_polarity,
    input wire logic cpol,
    input wire logic cpha
);
    // ****************************************
    // Frame tracking
    // ****************************************
    logic sel_act;
    logic sel_act_r;
    logic line_r;
    logic sck_r;
    logic in_frame_r;
    logic frame_start;
    logic frame_end;
    logic samp_edge;
    logic [5:0] tog_cnt_r;
    logic [4:0] samp_cnt_r;

    // A start needs a real move of the select line, so a polarity change alone is ignored.
    assign sel_act = (select_n_line == select_polarity);
    assign frame_start = sel_act && !sel_act_r && (select_n_line != line_r);
    assign frame_end = in_frame_r && !sel_act;
    assign samp_edge = (serial_clock_line != sck_r) && (serial_clock_line == (cpol ~^ cpha));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_act_r <= 1'b0;
            line_r <= 1'b1;
            sck_r <= 1'b0;
        end else begin
            sel_act_r <= sel_act;
            line_r <= select_n_line;
            sck_r <= serial_clock_line;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_frame_r <= 1'b0;
            tog_cnt_r <= 6'h00;
            samp_cnt_r <= 5'h00;
        end else if (!sel_act) begin
            in_frame_r <= 1'b0;
            tog_cnt_r <= 6'h00;
            samp_cnt_r <= 5'h00;
        end else begin
            if (frame_start) begin
                in_frame_r <= 1'b1;
            end
            if (serial_clock_line != sck_r) begin
                tog_cnt_r <= tog_cnt_r + 6'h01;
            end
            if (samp_edge) begin
                samp_cnt_r <= samp_cnt_r + 5'h01;
            end
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_toggles;
        frame_end |-> tog_cnt_r == 6'h20;
    endproperty
    a_toggles: assert property (p_toggles) else $error("frame clock edges not 32");
    property p_idle_start;
        frame_start |-> serial_clock_line == cpol;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("clock idle level at start");
    property p_idle_end;
        frame_end |-> serial_clock_line == cpol;
    endproperty
    a_idle_end: assert property (p_idle_end) else $error("clock idle level at end");
    property p_oe_late;
        $fell(sdo_oe_n) |-> in_frame_r && samp_cnt_r == 5'h08;
    endproperty
    a_oe_late: assert property (p_oe_late) else $error("output enabled off the data half");
    property p_oe_hold;
        $fell(sdo_oe_n) |-> !sdo_oe_n [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("output dropped during read data");
    property p_oe_release;
        !sel_act [*6] |-> sdo_oe_n;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("output driven while idle");
    property p_gap;
        frame_end |-> !sel_act [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");
    property p_sdi_hold;
        in_frame_r && samp_edge |-> $stable(sdi);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("input moved on sample edge");
    property p_frame_bound;
        frame_start |-> ##[1:400] !sel_act;
    endproperty
    a_frame_bound: assert property (p_frame_bound) else $error("frame never ends");

    c_start: cover property (frame_start);
    c_read: cover property ($fell(sdo_oe_n));
    c_mode3: cover property (frame_end && cpol && cpha);
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the paged serial register link.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psr_pkg::*;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic select_polarity = 1'b0;
    logic direction_polarity = 1'b0;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic page_auto_return = 1'b0;
    logic host_link_select = 1'b0;
    logic link_reset_enable = 1'b0;
    logic shutdown_request_pin = 1'b1;
    logic [1:0] active_page;
    logic four_wire_active;
    logic [31:0] rd_q;
    logic err_q;
    int n_errors = 0;
    int checks_done = 0;

    always #12.5 pclk = ~pclk;

    psr_link_if u_psr_link_if ();
    psr_host u_psr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(u_psr_link_if));
    psr_device u_psr_device (.pclk(pclk), .presetn(presetn), .link(u_psr_link_if),
        .select_polarity(select_polarity), .direction_polarity(direction_polarity),
        .cpol(cpol), .cpha(cpha), .page_auto_return(page_auto_return),
        .host_link_select(host_link_select), .link_reset_enable(link_reset_enable),
        .shutdown_request_pin(shutdown_request_pin), .active_page(active_page),
        .four_wire_active(four_wire_active));
    psr_link_sva u_psr_link_sva (.pclk(pclk), .presetn(presetn),
        .select_n_line(u_psr_link_if.select_n_line), .sdi(u_psr_link_if.sdi),
        .serial_clock_line(u_psr_link_if.serial_clock_line), .sdo_oe_n(u_psr_link_if.sdo_oe_n),
        .select_polarity(select_polarity), .cpol(cpol), .cpha(cpha));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle();
        apb(1'b0, OFS_STATUS, 32'h0);
        while (rd_q[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
    endtask

    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
        apb(1'b1, OFS_CMD, {16'h0000, rd, a, d});
        wait_idle();
        apb(1'b0, OFS_RDATA, 32'h0);
    endtask

    // Host and device settings change together, after the select gap has run out.
    task automatic cfg(input logic [3:0] c);
        repeat (20) @(posedge pclk);
        apb(1'b1, OFS_CFG, {28'h0, c});
        {cpha, cpol, direction_polarity, select_polarity} <= c;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        repeat (2) @(posedge pclk);
        check("page", {6'h0, active_page}, 8'h00);
        check("four wire", {7'h0, four_wire_active}, 8'h01);
        xfer(1'b1, PAGE_CTRL_ADDR, 8'h00);
        check("page reg", rd_q[7:0], 8'h00);
        xfer(1'b1, 7'h7f, 8'h00);
        check("reg 7f", rd_q[7:0], REG_RESET);
    endtask

    task automatic t_modes();
        for (int c = 0; c < 16; c++) begin
            cfg(4'(c));
            xfer(1'b0, 7'h10 + 7'(c), 8'hc0 ^ 8'(c));
            xfer(1'b1, 7'h10 + 7'(c), 8'h00);
            check("mode data", rd_q[7:0], 8'hc0 ^ 8'(c));
        end
        cfg(4'h0);
    endtask

    task automatic t_pages();
        xfer(1'b0, 7'h05, 8'h11);
        xfer(1'b0, PAGE_CTRL_ADDR, 8'h02);
        check("page", {6'h0, active_page}, 8'h02);
        xfer(1'b1, PAGE_CTRL_ADDR, 8'h00);
        check("page reg", rd_q[7:0], 8'h02);
        xfer(1'b1, 7'h05, 8'h00);
        check("page 2 reg", rd_q[7:0], REG_RESET);
        xfer(1'b0, 7'h05, 8'h22);
        xfer(1'b0, PAGE_CTRL_ADDR, 8'h00);
        xfer(1'b1, 7'h05, 8'h00);
        check("page 0 reg", rd_q[7:0], 8'h11);
        page_auto_return <= 1'b1;
        xfer(1'b0, PAGE_CTRL_ADDR, 8'h03);
        xfer(1'b1, 7'h05, 8'h00);
        check("auto page", {6'h0, active_page}, 8'h00);
        page_auto_return <= 1'b0;
    endtask

    // A shutdown pulse in mid-frame must cut the write only when enabled.
    task automatic t_shutdown();
        for (int en = 1; en >= 0; en--) begin
            link_reset_enable <= 1'(en);
            xfer(1'b0, 7'h20, 8'h5a);
            apb(1'b1, OFS_CMD, {16'h0000, 1'b0, 7'h20, 8'hc3});
            repeat (60) @(posedge pclk);
            shutdown_request_pin <= 1'b0;
            repeat (8) @(posedge pclk);
            shutdown_request_pin <= 1'b1;
            wait_idle();
            xfer(1'b1, 7'h20, 8'h00);
            check("after shutdown", rd_q[7:0], en ? 8'h5a : 8'hc3);
        end
        link_reset_enable <= 1'b0;
    endtask

    task automatic t_link_sel();
        host_link_select <= 1'b1;
        repeat (4) @(posedge pclk);
        check("four wire", {7'h0, four_wire_active}, 8'h00);
        xfer(1'b0, 7'h30, 8'h77);
        host_link_select <= 1'b0;
        repeat (4) @(posedge pclk);
        xfer(1'b1, 7'h30, 8'h00);
        check("ignored write", rd_q[7:0], REG_RESET);
        apb(1'b0, 8'h40, 32'h0);
        check("bus error", {7'h0, err_q}, 8'h01);
        check("bus data", rd_q[7:0], 8'h00);
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_pages();
        t_shutdown();
        t_link_sel();
        tally_and_finish();
    end
endmodule
